// >>> design/ssp_regs.svh
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL   4'h0
`define OFS_STATUS    4'h1
`define OFS_BUFFER    4'h2
`define OFS_ADDRESS   4'h3
`define OFS_MASK      4'h4
`define OFS_CONFIG    4'h5
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTL_WRITE_COLLISION_FLAG      7
`define CTL_OVF       6
`define CTL_EN        5
`define CTL_CKREL     4
`define CTL_RESET     8'h10
// ----------------------------------------
// status fields
// ----------------------------------------
`define STS_SLEW      7
`define STS_STOP      4
`define STS_START     3
`define STS_RW        2
`define STS_FULL      0
// ----------------------------------------
// config fields and resets
// ----------------------------------------
`define CFG_TENBIT    0
`define CFG_MASTER    1
`define MASK_RESET    8'hff
`define ADDR_RESET    8'h00
`endif

// >>> design/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_ADDR2 = 4'h3,
    ST_AACK2 = 4'h4,
    ST_RX    = 4'h5,
    ST_RACK  = 4'h6,
    ST_TX    = 4'h7,
    ST_TACK  = 4'h8,
    ST_SKIP  = 4'h9
  } state_t;
endpackage : ssp_pkg

// >>> design/line_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two flops, then edge detect on the clean copy
module line_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin
  input  wire logic din,
  // clean level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  always_comb
  begin
    nxt_meta = din;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;
endmodule : line_sync
`default_nettype wire

// >>> design/ssp_i2c_slave.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_regs.svh"
// Function
// [R1] all slave functions; general call address never acknowledged
// [R2] start and stop detected in hardware, each sets a sticky event flag
// [R3] 7-bit mode compares received address with programmed slave address
// [R4] 10-bit addressing selectable by config bit
// [R5] mask register picks which address bits are compared
// [R6] slew control bit drives pad slew limiter while enabled
// [R7] enable bit hands pins to port; clear returns them to gpio
// [R8] sample data on clock rise, change output data on clock fall
// [R9] driven data stays stable while clock is high
// [R10] software sets both pin directions to input first
// [R11] open drain pins, pulled low only when needed
// [R12] clock release bit clear holds clock low once sampled low
// [R13] buffer write during shift-out sets write collision, software clears
// [R14] slave overflow discards byte when buffer unread; never in master
module ssp_i2c_slave
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // bus pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // pad control
  input  wire logic       scl_dir_in,
  input  wire logic       sda_dir_in,
  output logic            pins_owned,
  output logic            slew_limit
);
  logic scl_s, scl_r, scl_f, sda_s, sda_r, sda_f;
  line_sync u_scl (.clk(clk), .rst_n(rst_n), .din(scl_in), .level(scl_s), .rise(scl_r), .fall(scl_f));
  line_sync u_sda (.clk(clk), .rst_n(rst_n), .din(sda_in), .level(sda_s), .rise(sda_r), .fall(sda_f));

  // ----------------------------------------
  // state
  // ----------------------------------------
  ssp_pkg::state_t st_ff, nxt_st;
  logic [7:0] ctl_ff, nxt_ctl, sts_ff, nxt_sts, buf_ff, nxt_buf;
  logic [7:0] sadr_ff, nxt_sadr, msk_ff, nxt_msk, cfg_ff, nxt_cfg;
  logic [7:0] sr_ff, nxt_sr, rdata_ff, nxt_rdata;
  logic [3:0] cnt_ff, nxt_cnt;
  logic       full_ff, nxt_full, sda_low_ff, nxt_sda_low, scl_low_ff, nxt_scl_low;
  logic       hit_ff, nxt_hit, own_ff, nxt_own, slew_ff, nxt_slew;
  logic       rw_ff, nxt_rw, start_ff, nxt_start, stop_ff, nxt_stop;

  function automatic logic match(input logic [7:0] a, input logic [7:0] b,
                                 input logic [7:0] m);
    match = ((a ^ b) & m) == 8'h00; // [R5]
  endfunction : match

  logic en, ten, shifting, bufwr, bufrd;
  logic is_start, is_stop, byte_done;
  assign en        = ctl_ff[`CTL_EN];
  assign ten       = cfg_ff[`CFG_TENBIT];
  assign shifting  = (st_ff == ssp_pkg::ST_TX);
  assign bufwr     = wr && addr == `OFS_BUFFER;
  assign bufrd     = rd && addr == `OFS_BUFFER;
  assign is_start  = en && scl_s && sda_f; // [R2]
  assign is_stop   = en && scl_s && sda_r; // [R2]
  assign byte_done = scl_r && cnt_ff == 4'h7;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff; nxt_ctl = ctl_ff; nxt_sts = sts_ff; nxt_buf = buf_ff;
    nxt_sadr = sadr_ff; nxt_msk = msk_ff; nxt_cfg = cfg_ff; nxt_sr = sr_ff;
    nxt_cnt = cnt_ff; nxt_full = full_ff; nxt_sda_low = sda_low_ff;
    nxt_hit = hit_ff; nxt_rw = rw_ff; nxt_rdata = 8'h00;
    nxt_start = start_ff; nxt_stop = stop_ff;
    nxt_scl_low = scl_low_ff;
    nxt_own  = en && scl_dir_in && sda_dir_in; // [R7] [R10] [R11]
    nxt_slew = en && sts_ff[`STS_SLEW]; // [R6]
    if (wr)
      unique case (addr)
        `OFS_CONTROL: nxt_ctl = wdata;
        `OFS_STATUS:  nxt_sts = wdata;
        `OFS_BUFFER:  nxt_buf = wdata;
        `OFS_ADDRESS: nxt_sadr = wdata;
        `OFS_MASK:    nxt_msk = wdata;
        `OFS_CONFIG:  nxt_cfg = wdata;
        default:      ;
      endcase
    if (bufwr)
      nxt_full = 1'b1;
    if (bufrd)
      nxt_full = 1'b0;
    if (bufwr && shifting)
      nxt_ctl[`CTL_WRITE_COLLISION_FLAG] = 1'b1; // [R13]
    // [R12] stretch only after the master pulled clock low itself
    if (!ctl_ff[`CTL_CKREL] && !scl_s && st_ff != ssp_pkg::ST_IDLE)
      nxt_scl_low = 1'b1;
    if (ctl_ff[`CTL_CKREL])
      nxt_scl_low = 1'b0;
    if (scl_r)
      nxt_sr = {sr_ff[6:0], sda_s}; // [R8]
    if (scl_r)
      nxt_cnt = cnt_ff + 4'h1;
    unique case (st_ff)
      ssp_pkg::ST_IDLE: nxt_sda_low = 1'b0;
      ssp_pkg::ST_ADDR, ssp_pkg::ST_ADDR2, ssp_pkg::ST_RX:
        if (byte_done)
        begin
          if (st_ff == ssp_pkg::ST_ADDR)
          begin
            nxt_rw = sda_s;
            // [R1] general call never hits; [R3] [R4]
            nxt_hit = ({sr_ff[6:0], sda_s} != 8'h00) && (ten ?
              match({sr_ff[6:0], 1'b0}, {5'h1e, sadr_ff[2:1], 1'b0}, {msk_ff[7:1], 1'b0}) :
              match({sr_ff[6:0], 1'b0}, {sadr_ff[7:1], 1'b0}, {msk_ff[7:1], 1'b0}));
          end
          else if (st_ff == ssp_pkg::ST_ADDR2)
            nxt_hit = match(sr_ff[6:0] == 7'h00 ? 8'h00 : {sr_ff[6:0], sda_s}, sadr_ff, msk_ff);
          else if (full_ff)
            nxt_ctl[`CTL_OVF] = !cfg_ff[`CFG_MASTER]; // [R14]
          else
          begin
            nxt_buf = {sr_ff[6:0], sda_s};
            nxt_full = 1'b1;
          end
          nxt_st = ssp_pkg::state_t'(st_ff + 4'h1);
        end
      ssp_pkg::ST_AACK, ssp_pkg::ST_AACK2, ssp_pkg::ST_RACK, ssp_pkg::ST_TACK:
      begin
        // [R8] [R9] drive ack right after the fall
        if (scl_f && cnt_ff == 4'h8)
          nxt_sda_low = st_ff != ssp_pkg::ST_TACK && hit_ff &&
                        !(st_ff == ssp_pkg::ST_RACK && ctl_ff[`CTL_OVF]);
        if (scl_r)
          nxt_rdata = {7'h00, sda_s};
        if (scl_f && cnt_ff == 4'h9)
        begin
          nxt_cnt = 4'h0;
          nxt_sda_low = 1'b0;
          if (!hit_ff || (st_ff == ssp_pkg::ST_TACK && sda_s))
            nxt_st = ssp_pkg::ST_SKIP;
          else if (st_ff == ssp_pkg::ST_AACK && ten && !rw_ff)
            nxt_st = ssp_pkg::ST_ADDR2;
          else if ((st_ff == ssp_pkg::ST_AACK && rw_ff) || st_ff == ssp_pkg::ST_TACK)
          begin
            nxt_st = ssp_pkg::ST_TX;
            nxt_sr = buf_ff;
            nxt_full = 1'b0;
            nxt_sda_low = !buf_ff[7]; // [R8]
          end
          else
            nxt_st = ssp_pkg::ST_RX;
        end
      end
      ssp_pkg::ST_TX:
      begin
        if (scl_r)
          nxt_sr = sr_ff;
        if (scl_f)
        begin
          nxt_sr = {sr_ff[6:0], 1'b0};
          nxt_sda_low = !sr_ff[6]; // [R8] [R9]
        end
        if (scl_f && cnt_ff == 4'h8)
        begin
          nxt_sda_low = 1'b0;
          nxt_st = ssp_pkg::ST_TACK;
        end
      end
      ssp_pkg::ST_SKIP: nxt_sda_low = 1'b0;
      default: nxt_st = ssp_pkg::ST_IDLE;
    endcase
    if (is_start)
    begin
      nxt_start = 1'b1; // [R2]
      nxt_st = ssp_pkg::ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_sda_low = 1'b0;
    end
    if (is_stop)
    begin
      nxt_stop = 1'b1; // [R2]
      nxt_st = ssp_pkg::ST_IDLE;
    end
    if (wr && addr == `OFS_STATUS)
    begin
      nxt_start = (start_ff & wdata[`STS_START]) | is_start;
      nxt_stop  = (stop_ff & wdata[`STS_STOP]) | is_stop;
    end
    if (!en)
    begin
      nxt_st = ssp_pkg::ST_IDLE; // [R7]
      nxt_sda_low = 1'b0;
      nxt_scl_low = 1'b0;
    end
    // pins not handed over: never pull either line
    if (!nxt_own)
    begin
      nxt_sda_low = 1'b0; // [R11]
      nxt_scl_low = 1'b0; // [R11]
    end
    if (rd)
      unique case (addr)
        `OFS_CONTROL: nxt_rdata = ctl_ff;
        `OFS_STATUS:  nxt_rdata = {sts_ff[7:5], stop_ff, start_ff, rw_ff, 1'b0, full_ff};
        `OFS_BUFFER:  nxt_rdata = buf_ff;
        `OFS_ADDRESS: nxt_rdata = sadr_ff;
        `OFS_MASK:    nxt_rdata = msk_ff;
        `OFS_CONFIG:  nxt_rdata = cfg_ff;
        default:      nxt_rdata = 8'h00;
      endcase
    else
      nxt_rdata = 8'h00;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ssp_pkg::ST_IDLE; ctl_ff <= `CTL_RESET; sts_ff <= 8'h00;
      buf_ff <= 8'h00; sadr_ff <= `ADDR_RESET; msk_ff <= `MASK_RESET;
      cfg_ff <= 8'h00; sr_ff <= 8'h00; cnt_ff <= 4'h0; full_ff <= 1'b0;
      sda_low_ff <= 1'b0; scl_low_ff <= 1'b0; hit_ff <= 1'b0; rw_ff <= 1'b0;
      own_ff <= 1'b0; slew_ff <= 1'b0; start_ff <= 1'b0; stop_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      st_ff <= nxt_st; ctl_ff <= nxt_ctl; sts_ff <= nxt_sts;
      buf_ff <= nxt_buf; sadr_ff <= nxt_sadr; msk_ff <= nxt_msk;
      cfg_ff <= nxt_cfg; sr_ff <= nxt_sr; cnt_ff <= nxt_cnt; full_ff <= nxt_full;
      sda_low_ff <= nxt_sda_low; scl_low_ff <= nxt_scl_low; hit_ff <= nxt_hit;
      rw_ff <= nxt_rw; own_ff <= nxt_own; slew_ff <= nxt_slew;
      start_ff <= nxt_start; stop_ff <= nxt_stop; rdata_ff <= nxt_rdata;
    end
  end

  // open drain: value is always low, enable pulls
  assign rdata      = rdata_ff;
  assign scl_out    = 1'b0; // [R11]
  assign sda_out    = 1'b0; // [R11]
  assign scl_oe     = scl_low_ff; // [R12]
  assign sda_oe     = sda_low_ff; // [R11]
  assign pins_owned = own_ff;
  assign slew_limit = slew_ff;
endmodule : ssp_i2c_slave
`default_nettype wire

// >>> testbench/ssp_i2c_slave_props.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_i2c_slave_props
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_dir_in,
  input wire logic       sda_dir_in,
  input wire logic       pins_owned
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_scl_out_low: assert property (scl_out == 1'b0) else $error("scl_out not low");
  a_sda_out_low: assert property (sda_out == 1'b0) else $error("sda_out not low");
  a_pins_dir: assert property (!(scl_dir_in && sda_dir_in) |=> !pins_owned)
    else $error("pins owned with an output direction");
  a_oe_unowned: assert property (!pins_owned && !$past(pins_owned) |-> !scl_oe && !sda_oe)
    else $error("line pulled while pins not owned");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_sda_hold: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
    else $error("sda moved while clock high");
  a_drive_span: assert property ($rose(sda_oe) |-> sda_oe [*6]) else $error("sda pull too short");
  a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in, 2) && !scl_in)
    else $error("clock held without being low");
endmodule : ssp_i2c_slave_props
bind ssp_i2c_slave ssp_i2c_slave_props ssp_i2c_slave_props_inst (.clk(clk), .rst_n(rst_n),
  .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_dir_in(scl_dir_in), .sda_dir_in(sda_dir_in),
  .pins_owned(pins_owned));
`default_nettype wire

// >>> testbench/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// bus master; both lines have pull-ups outside
module i2c_master_model
(
  // resolved line levels
  input  wire logic scl,
  input  wire logic sda,
  // pull-downs
  output var logic  scl_low,
  output var logic  sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // bounded, so a clock held for ever cannot hang the run
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (!scl && n < 2000)
    begin
      #20;
      n++;
    end
  endtask : rise
  task automatic start();
    sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask : start
  task automatic stop();
    #40 sda_low = 1'b1;
    #40 rise();
    #80 sda_low = 1'b0;
    #80;
  endtask : stop
  // ninth bit always released: ack comes from the slave
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ak);
    logic [8:0] sh;
    sh = {tx, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      #40 sda_low = !sh[i];
      #40 rise();
      #40 sh[i] = sda;
      #40 scl_low = 1'b1;
    end
    rx = sh[8:1];
    ak = !sh[0];
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// >>> testbench/ssp_i2c_slave_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_i2c_slave_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic scl_dir_in = 1'b0, sda_dir_in = 1'b0, ak;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, d0, d1, rx;
  logic scl_out, scl_oe, sda_out, sda_oe, pins_owned, slew_limit;
  wire logic m_scl_low, m_sda_low;
  // pull-up: a released line reads high
  wire logic scl = !(scl_oe || m_scl_low);
  wire logic sda = !(sda_oe || m_sda_low);
  logic [7:0] exp_q[$];
  int n_fail = 0, total_checks = 0;
  always #10 clk = ~clk;
  ssp_i2c_slave ssp_i2c_slave_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_dir_in(scl_dir_in),
    .sda_dir_in(sda_dir_in), .pins_owned(pins_owned), .slew_limit(slew_limit));
  i2c_master_model i2c_master_model_inst (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, e, s);
    end
  endtask : cmp
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : reg_rd
  task automatic frame(input logic [7:0] a, input logic e);
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(a, rx, ak);
    cmp("addr ack", {7'h0, e}, {7'h0, ak});
  endtask : frame
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d) cmp("rdata", exp_q.pop_front(), rdata);
    rd_d <= rd;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'he955));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(4'h0, 8'h10);
    reg_rd(4'h4, 8'hff);
    reg_rd(4'h3, 8'h00);
    reg_rd(4'h5, 8'h00);
    reg_rd(4'hf, 8'h00);
    scl_dir_in <= 1'b1; sda_dir_in <= 1'b1;
    reg_wr(4'h3, 8'h84);
    reg_wr(4'h1, 8'h80);
    reg_wr(4'h0, 8'h36);
    repeat (3) @(posedge clk);
    cmp("owned", 8'h01, {7'h0, pins_owned});
    cmp("slew", 8'h01, {7'h0, slew_limit});
    frame(8'h84, 1'b1);
    i2c_master_model_inst.xfer(d0, rx, ak);
    cmp("data ack", 8'h01, {7'h0, ak});
    i2c_master_model_inst.xfer(d1, rx, ak);
    cmp("ovf ack", 8'h00, {7'h0, ak});
    i2c_master_model_inst.stop();
    reg_rd(4'h0, 8'h76);
    reg_rd(4'h1, 8'h99);
    reg_rd(4'h2, d0);
    reg_wr(4'h0, 8'h36);
    frame(8'h00, 1'b0);
    i2c_master_model_inst.stop();
    frame(8'h86, 1'b0);
    i2c_master_model_inst.stop();
    reg_wr(4'h4, 8'hf0);
    frame(8'h8e, 1'b1);
    i2c_master_model_inst.stop();
    reg_wr(4'h4, 8'hff);
    // ten-bit: upper bits 2'b11 in first byte, full low byte second
    reg_wr(4'h3, 8'h06);
    reg_wr(4'h5, 8'h01);
    frame(8'hf6, 1'b1);
    i2c_master_model_inst.xfer(8'h06, rx, ak);
    cmp("tenbit ack", 8'h01, {7'h0, ak});
    i2c_master_model_inst.stop();
    reg_wr(4'h5, 8'h00);
    reg_wr(4'h3, 8'h84);
    reg_wr(4'h0, 8'h26);
    fork
      frame(8'h84, 1'b1);
      begin
        repeat (60) @(posedge clk);
        cmp("held", 8'h01, {7'h0, scl_oe});
        reg_wr(4'h0, 8'h36);
      end
    join
    i2c_master_model_inst.stop();
    reg_wr(4'h2, d1);
    frame(8'h85, 1'b1);
    fork
      i2c_master_model_inst.xfer(8'hff, rx, ak);
      begin
        repeat (30) @(posedge clk);
        reg_wr(4'h2, 8'h5a);
      end
    join
    cmp("tx data", d1, rx);
    i2c_master_model_inst.stop();
    reg_rd(4'h0, 8'hb6);
    sda_dir_in <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("dir out", 8'h00, {7'h0, pins_owned});
    reg_wr(4'h0, 8'h06);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule : ssp_i2c_slave_tb_top
`default_nettype wire
